/* File: hw/acc_pkg.sv */
package acc_pkg;

    // ------------------------------------------------------------
    // register map, byte offsets on the plain register port
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam logic [4:0] OFS_CTRL0 = 5'h00; // converter_control_reg0
    localparam logic [4:0] OFS_CHAN = 5'h04; // channel_select_reg
    localparam logic [4:0] OFS_REF = 5'h08; // reference selects
    localparam logic [4:0] OFS_CLKDIV = 5'h0C; // clock_divider_code
    localparam logic [4:0] OFS_FLAG = 5'h10; // peripheral_flag_reg
    localparam logic [4:0] OFS_IRQEN = 5'h14; // enables of the interrupt path
    localparam logic [4:0] OFS_STAT = 5'h18; // read-only state

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CTL_ON = 7;
    localparam int unsigned CTL_CONTINUOUS_MODE = 6;
    localparam int unsigned CTL_CS = 4;
    localparam int unsigned CTL_GO = 0;
    localparam int unsigned REF_NEG = 4;
    localparam int unsigned IEN_CONV = 0;
    localparam int unsigned IEN_PERI = 1;
    localparam int unsigned IEN_GLOB = 2;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] CH_FVR2 = 6'h3F;
    localparam logic [5:0] CH_FVR1 = 6'h3E;
    localparam logic [5:0] CH_DAC = 6'h3D;
    localparam logic [5:0] CH_TEMP = 6'h3C;
    localparam logic [5:0] CH_AGND = 6'h3B;
    localparam logic [5:0] CH_HOLE = 6'h03;
    localparam logic [5:0] CH_LAST_PIN = 6'h17;
    localparam logic [2:0] POS_REF_SELECT_PIN = 3'h0;
    localparam logic [2:0] POS_REF_SELECT_VDD = 3'h1;
    localparam logic [2:0] POS_REF_SELECT_F1X = 3'h2;
    localparam logic [2:0] POS_REF_SELECT_F2X = 3'h3;
    localparam logic [2:0] POS_REF_SELECT_F4X = 3'h4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ACC_SRC_NONE = 3'h0,
        ACC_SRC_PORTA = 3'h1,
        ACC_SRC_PORTB = 3'h2,
        ACC_SRC_PORTC = 3'h3,
        ACC_SRC_INT = 3'h4
    } acc_src_e;

    typedef enum logic [2:0] {
        ACC_POS_REF_SELECT_PIN = 3'h0,
        ACC_POS_REF_SELECT_VDD = 3'h1,
        ACC_POS_REF_SELECT_F1X = 3'h2,
        ACC_POS_REF_SELECT_F2X = 3'h3,
        ACC_POS_REF_SELECT_F4X = 3'h4
    } acc_pos_ref_select_e;

    // analog multiplexer select; idx is pin number or internal 0..4
    typedef struct packed {
        acc_src_e src;
        logic [2:0] idx;
    } acc_mux_s;

    // reference select toward the core
    typedef struct packed {
        acc_pos_ref_select_e pos;
        logic neg_pin;
    } acc_ref_s;

endpackage

/* File: hw/acc_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none

module acc_clkdiv
    import acc_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // control
    input wire logic [5:0] i_div_code,
    input wire logic i_src_rc,
    input wire logic i_rc_edge,
    // conversion clock
    output logic o_tick,
    output logic o_conv_clk
);

    logic [6:0] cnt_q;
    logic [5:0] code_q;
    logic src_q;
    logic restart;

    // -------------------------------------------------------------
    // restart on any change of code or source
    // -------------------------------------------------------------
    // restart on change
    assign restart = (code_q != i_div_code) || (src_q != i_src_rc);

    // track the settings last seen
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            code_q <= 6'h00;
            src_q <= 1'b0;
        end
        else
        begin
            code_q <= i_div_code;
            src_q <= i_src_rc;
        end
    end

    // half-period counter, toggles every code+1 cycles
    // divide by two times code+1
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 7'h00;
            o_conv_clk <= 1'b0;
            o_tick <= 1'b0;
        end
        else if (restart)
        begin
            cnt_q <= 7'h00;
            o_conv_clk <= 1'b0;
            o_tick <= 1'b0;
        end
        else if (i_src_rc)
        begin
            cnt_q <= 7'h00;
            o_conv_clk <= i_rc_edge;
            o_tick <= i_rc_edge;
        end
        else if (cnt_q == {1'b0, i_div_code})
        begin
            cnt_q <= 7'h00;
            o_conv_clk <= ~o_conv_clk;
            o_tick <= ~o_conv_clk;
        end
        else
        begin
            cnt_q <= cnt_q + 7'h01;
            o_tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: hw/acc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module acc_ctrl
    import acc_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // asynchronous inputs
    input wire logic i_rc_osc,
    input wire logic i_ext_trig,
    input wire logic i_core_done,
    // core power state, same clock
    input wire logic i_sleep,
    // toward the converter core
    output acc_mux_s o_mux,
    output acc_ref_s o_ref,
    output logic o_core_on,
    output logic o_conv_run,
    output logic o_conv_clk,
    output logic o_conv_tick,
    // toward the processor core
    output logic o_irq,
    output logic o_wake,
    output logic o_resume_inline
);

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } acc_state_e;

    acc_state_e state_q;
    logic on_q, continuous_mode_q, cs_q, go_q;
    logic [5:0] chan_q, div_q;
    logic [2:0] pos_ref_select_q;
    logic neg_ref_select_q;
    logic flag_q;
    logic [2:0] ien_q;
    logic off_q;
    logic [2:0] sync1_q, sync2_q, prev_q;
    logic rc_edge, trig_edge, done_ev;
    logic tick, conv_clk;
    logic may_run, apply;
    logic wr_ctrl, wr_flag_clr;

    // -------------------------------------------------------------
    // channel decode
    // -------------------------------------------------------------
    function automatic acc_mux_s chan_decode(input logic [5:0] code);
        acc_mux_s m;
        m.src = ACC_SRC_NONE;
        m.idx = code[2:0];
        if (code <= CH_LAST_PIN && code != CH_HOLE)
        begin
            unique case (code[4:3])
                2'b00: m.src = ACC_SRC_PORTA;
                2'b01: m.src = ACC_SRC_PORTB;
                default: m.src = ACC_SRC_PORTC;
            endcase
        end
        else if (code >= CH_AGND)
        begin
            // internal sources, idx 0 ground .. 4 second ref
            m.src = ACC_SRC_INT;
            m.idx = 3'(code - CH_AGND);
        end
        else
        begin
            m.src = ACC_SRC_NONE;
            m.idx = 3'h0;
        end
        return m;
    endfunction

    // reference decode, unused codes fall back to supply
    function automatic acc_ref_s ref_decode(input logic [2:0] p, input logic n);
        acc_ref_s r;
        r.neg_pin = n;
        unique case (p)
            POS_REF_SELECT_PIN: r.pos = ACC_POS_REF_SELECT_PIN;
            POS_REF_SELECT_F1X: r.pos = ACC_POS_REF_SELECT_F1X;
            POS_REF_SELECT_F2X: r.pos = ACC_POS_REF_SELECT_F2X;
            POS_REF_SELECT_F4X: r.pos = ACC_POS_REF_SELECT_F4X;
            default: r.pos = ACC_POS_REF_SELECT_VDD;
        endcase
        return r;
    endfunction

    // -------------------------------------------------------------
    // input synchronisers and edge detect
    // -------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 3'h0;
        end
        else
        begin
            sync1_q <= {i_core_done, i_ext_trig, i_rc_osc};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign rc_edge = sync2_q[0] & ~prev_q[0];
    assign trig_edge = sync2_q[1] & ~prev_q[1];
    assign done_ev = sync2_q[2] & ~prev_q[2] & (state_q == ST_CONV);

    // -------------------------------------------------------------
    // conversion clock divider
    // -------------------------------------------------------------
    acc_clkdiv u_div (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_div_code(div_q),
        .i_src_rc(cs_q),
        .i_rc_edge(rc_edge),
        .o_tick(tick),
        .o_conv_clk(conv_clk)
    );

    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    assign wr_ctrl = i_wr && (i_addr == OFS_CTRL0);
    assign wr_flag_clr = i_wr && (i_addr == OFS_FLAG) && i_wdata[0];

    // configuration fields
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            on_q <= 1'b0;
            continuous_mode_q <= 1'b0;
            cs_q <= 1'b0;
            chan_q <= 6'h00;
            div_q <= 6'h00;
            pos_ref_select_q <= 3'h0;
            neg_ref_select_q <= 1'b0;
            ien_q <= 3'h0;
        end
        else if (i_wr)
        begin
            unique case (i_addr)
                OFS_CTRL0:
                begin
                    on_q <= i_wdata[CTL_ON];
                    continuous_mode_q <= i_wdata[CTL_CONTINUOUS_MODE];
                    cs_q <= i_wdata[CTL_CS];
                end
                OFS_CHAN: chan_q <= i_wdata[5:0];
                OFS_REF:
                begin
                    pos_ref_select_q <= i_wdata[2:0];
                    neg_ref_select_q <= i_wdata[REF_NEG];
                end
                OFS_CLKDIV: div_q <= i_wdata[5:0];
                OFS_IRQEN: ien_q <= i_wdata[2:0];
                default: ien_q <= ien_q;
            endcase
        end
    end

    // -------------------------------------------------------------
    // start bit
    // -------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            go_q <= 1'b0;
        else if (!on_q || (wr_ctrl && !i_wdata[CTL_ON]))
            go_q <= 1'b0;
        else if (trig_edge || (wr_ctrl && i_wdata[CTL_GO]))
            go_q <= 1'b1;
        else if (wr_ctrl)
            go_q <= 1'b0;
        else if (done_ev && !continuous_mode_q)
            go_q <= 1'b0;
    end

    // -------------------------------------------------------------
    // conversion sequencer
    // -------------------------------------------------------------
    // sleep runs only on rc; other triggers wait for wake
    assign may_run = on_q && go_q && !off_q && (!i_sleep || cs_q);

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            state_q <= ST_IDLE;
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    // rc source waits one conversion clock first
                    if (may_run)
                        state_q <= cs_q ? ST_WAIT : ST_CONV;
                ST_WAIT:
                    if (!may_run)
                        state_q <= ST_IDLE;
                    else if (tick)
                        state_q <= ST_CONV;
                ST_CONV:
                    if (done_ev || !may_run)
                        state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // core shut off after a sleep conversion with no interrupt
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            off_q <= 1'b0;
        else if (!i_sleep || !on_q)
            off_q <= 1'b0;
        else if (done_ev && !ien_q[IEN_CONV])
            off_q <= 1'b1;
    end

    // -------------------------------------------------------------
    // done flag
    // -------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            flag_q <= 1'b0;
        // set on every completion, set beats clear
        else if (done_ev)
            flag_q <= 1'b1;
        else if (wr_flag_clr)
            flag_q <= 1'b0;
    end

    // -------------------------------------------------------------
    // outputs toward the core
    // -------------------------------------------------------------
    // with rc source, settings apply on its edges only
    assign apply = !cs_q || tick;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_mux <= '0;
            o_ref <= '0;
        end
        else if (apply)
        begin
            o_mux <= chan_decode(chan_q);
            o_ref <= ref_decode(pos_ref_select_q, neg_ref_select_q);
        end
    end

    // run and clock outputs
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_core_on <= 1'b0;
            o_conv_run <= 1'b0;
            o_conv_clk <= 1'b0;
            o_conv_tick <= 1'b0;
        end
        else
        begin
            o_core_on <= on_q && !off_q;
            o_conv_run <= (state_q == ST_CONV) && may_run;
            o_conv_clk <= conv_clk;
            o_conv_tick <= tick;
        end
    end

    // interrupt and wake
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_irq <= 1'b0;
            o_wake <= 1'b0;
            o_resume_inline <= 1'b0;
        end
        else
        begin
            o_irq <= flag_q && ien_q[IEN_CONV];
            o_wake <= flag_q && ien_q[IEN_CONV] && i_sleep;
            o_resume_inline <= flag_q && ien_q[IEN_CONV] && ien_q[IEN_PERI]
                && !ien_q[IEN_GLOB] && i_sleep;
        end
    end

    // -------------------------------------------------------------
    // register reads, data in the following cycle
    // -------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= RST_BYTE;
        else if (i_rd)
        begin
            unique case (i_addr)
                OFS_CTRL0: o_rdata <= {on_q, continuous_mode_q, 1'b0, cs_q, 3'h0, go_q};
                OFS_CHAN: o_rdata <= {2'h0, chan_q};
                OFS_REF: o_rdata <= {3'h0, neg_ref_select_q, 1'b0, pos_ref_select_q};
                OFS_CLKDIV: o_rdata <= {2'h0, div_q};
                OFS_FLAG: o_rdata <= {7'h00, flag_q};
                OFS_IRQEN: o_rdata <= {5'h00, ien_q};
                OFS_STAT: o_rdata <= {3'h0, off_q, 1'b0, state_q};
                default: o_rdata <= RST_BYTE;
            endcase
        end
        else
            o_rdata <= RST_BYTE;
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    logic [7:0] gap_q;
    logic [5:0] div_seen_q;
    logic cs_seen_q, per_ok_q;
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            gap_q <= 8'h00;
        else if (tick || cs_q)
            gap_q <= 8'h01;
        else
            gap_q <= gap_q + 8'h01;
    end

    // a period counts only between two ticks of one setting, as the divider restarts
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_seen_q <= 6'h00;
            cs_seen_q <= 1'b0;
            per_ok_q <= 1'b0;
        end
        else
        begin
            div_seen_q <= div_q;
            cs_seen_q <= cs_q;
            if ((div_seen_q != div_q) || (cs_seen_q != cs_q) || cs_q)
                per_ok_q <= 1'b0;
            else if (tick)
                per_ok_q <= 1'b1;
        end
    end

    sequence s_done_seen;
        done_ev && !wr_flag_clr;
    endsequence

    a_flag_on_done: assert property (@(posedge i_mclk) disable iff (i_rst)
        done_ev |=> flag_q ##1 (o_irq == ien_q[IEN_CONV]))
        else $error("flag not set by completion");
    a_flag_sticky: assert property (@(posedge i_mclk) disable iff (i_rst)
        flag_q && !wr_flag_clr |=> flag_q)
        else $error("flag dropped without software clear");
    a_go_cleared: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_done_seen ##0 (!continuous_mode_q && !wr_ctrl && !trig_edge) |=> !go_q)
        else $error("start bit kept after completion");
    a_irq_follows: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_irq == $past(flag_q && ien_q[IEN_CONV]))
        else $error("interrupt output wrong");
    a_sleep_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_sleep && !cs_q |=> !o_conv_run)
        else $error("conversion in sleep without rc");
    a_off_no_run: assert property (@(posedge i_mclk) disable iff (i_rst)
        !on_q |=> !o_conv_run ##1 !o_conv_run)
        else $error("converter ran while disabled");
    a_reserved_none: assert property (@(posedge i_mclk) disable iff (i_rst)
        !cs_q && (chan_q == CH_HOLE || (chan_q > CH_LAST_PIN && chan_q < CH_AGND))
        |=> o_mux.src == ACC_SRC_NONE)
        else $error("reserved channel connected");
    a_div_period: assert property (@(posedge i_mclk) disable iff (i_rst)
        tick && !cs_q && per_ok_q && $stable(div_q) && $past(!cs_q) && gap_q > 8'h01
        |-> gap_q == 8'(({2'h0, div_q} + 8'h01) << 1))
        else $error("divider period wrong");
    a_inline_wake: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_resume_inline |-> o_wake && $past(ien_q[IEN_PERI] && !ien_q[IEN_GLOB]))
        else $error("inline resume without wake");

endmodule

`default_nettype wire

/* File: test/acc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// converter core and rc oscillator model
// ------------------------------------------------------------
module acc_core_model #(
    parameter int DLY = 12,
    parameter int RC_HALF = 5
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // from the control block
    input wire logic i_run,
    // toward the control block
    output logic o_done,
    output logic o_rc
);
    int cnt_q;
    int rc_q;

    // completion level after a fixed conversion time, dropped with run
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 0;
            o_done <= 1'b0;
        end
        else
        begin
            cnt_q <= i_run ? cnt_q + 1 : 0;
            o_done <= i_run && (cnt_q >= DLY);
        end
    end

    // free running rc oscillator, period of 2*RC_HALF system cycles
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rc_q <= 0;
            o_rc <= 1'b0;
        end
        else
        begin
            rc_q <= (rc_q == RC_HALF - 1) ? 0 : rc_q + 1;
            if (rc_q == RC_HALF - 1)
                o_rc <= ~o_rc;
        end
    end
endmodule

`default_nettype wire

/* File: test/tb_adc_config_control.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// testbench
// ------------------------------------------------------------
module tb_adc_config_control
    import acc_pkg::*;
;
    typedef struct packed {
        logic [4:0] a;
        logic [7:0] d;
        logic [5:0] e;
    } acc_row_s;

    logic i_mclk, i_rst, i_wr, i_rd, i_ext_trig, i_sleep, rc_osc, core_done;
    logic [4:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    acc_mux_s o_mux;
    acc_ref_s o_ref;
    logic o_core_on, o_conv_run, o_conv_clk, o_conv_tick, o_irq, o_wake, o_resume_inline;
    int errors, n_tests, cycles, n;
    logic [5:0] got;
    acc_row_s rows[20] = '{
        '{OFS_CHAN, 8'h3F, 6'h24}, '{OFS_CHAN, 8'h3E, 6'h23}, '{OFS_CHAN, 8'h3D, 6'h22},
        '{OFS_CHAN, 8'h3C, 6'h21}, '{OFS_CHAN, 8'h3B, 6'h20}, '{OFS_CHAN, 8'h00, 6'h08},
        '{OFS_CHAN, 8'h07, 6'h0F}, '{OFS_CHAN, 8'h08, 6'h10}, '{OFS_CHAN, 8'h0F, 6'h17},
        '{OFS_CHAN, 8'h10, 6'h18}, '{OFS_CHAN, 8'h17, 6'h1F}, '{OFS_CHAN, 8'h03, 6'h00},
        '{OFS_CHAN, 8'h18, 6'h00}, '{OFS_CHAN, 8'h3A, 6'h00}, '{OFS_REF, 8'h00, 6'h00},
        '{OFS_REF, 8'h01, 6'h02}, '{OFS_REF, 8'h02, 6'h04}, '{OFS_REF, 8'h03, 6'h06},
        '{OFS_REF, 8'h04, 6'h08}, '{OFS_REF, 8'h14, 6'h09}};

    acc_ctrl i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rc_osc(rc_osc),
        .i_ext_trig(i_ext_trig), .i_core_done(core_done), .i_sleep(i_sleep), .o_mux(o_mux),
        .o_ref(o_ref), .o_core_on(o_core_on), .o_conv_run(o_conv_run),
        .o_conv_clk(o_conv_clk), .o_conv_tick(o_conv_tick), .o_irq(o_irq),
        .o_wake(o_wake), .o_resume_inline(o_resume_inline));

    acc_core_model i_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_run(o_conv_run),
        .o_done(core_done), .o_rc(rc_osc));

    // clock and hang guard
    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        check("rdata", o_rdata, e);
    endtask

    // bounded wait for run to reach a level
    task automatic wait_run(input logic v);
        for (int k = 0; k < 300 && o_conv_run !== v; k++)
            @(posedge i_mclk);
        #1;
        check("run", o_conv_run, v);
    endtask

    // cycles between two rising conversion clock pulses, past the divider restart
    task automatic tick_period(output int p);
        repeat (2) @(posedge i_mclk);
        #1;
        for (int k = 0; k < 300 && o_conv_tick !== 1'b1; k++)
        begin
            @(posedge i_mclk);
            #1;
        end
        check("conv_clk", o_conv_clk, 1'b1);
        p = 0;
        do
        begin
            @(posedge i_mclk);
            #1;
            p++;
        end
        while (o_conv_tick !== 1'b1 && p < 300);
    endtask

    initial
    begin
        {i_rst, i_wr, i_rd, i_ext_trig, i_sleep} = 5'h10;
        i_addr = 5'h00;
        i_wdata = 8'h00;
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        foreach (rows[k])
        begin
            wr(rows[k].a, rows[k].d);
            repeat (3) @(posedge i_mclk);
            got = o_mux;
            if (rows[k].a != OFS_CHAN)
                got = {2'h0, o_ref};
            check("select", got, rows[k].e);
        end
        wr(OFS_CTRL0, 8'h80);
        foreach (rows[k])
        begin
            if (k < 3)
            begin
                wr(OFS_CLKDIV, {2'h0, rows[k * 5].d[5:0] & 6'h3F});
            end
        end
        wr(OFS_CLKDIV, 8'h03);
        tick_period(n);
        check("div8", n, 8);
        check("core_on", o_core_on, 1'b1);
        wr(OFS_CLKDIV, 8'h00);
        tick_period(n);
        check("div2", n, 2);
        wr(OFS_CLKDIV, 8'h3F);
        tick_period(n);
        check("div128", n, 128);
        wr(OFS_CTRL0, 8'h90);
        tick_period(n);
        check("rc", n, 10);
        wr(OFS_CTRL0, 8'h80);
        wr(OFS_CLKDIV, 8'h00);
        // settling wait after a channel change
        wr(OFS_CHAN, 8'h05);
        repeat (20) @(posedge i_mclk);
        wr(OFS_IRQEN, 8'h03);
        wr(OFS_CTRL0, 8'h81);
        wait_run(1'b1);
        wait_run(1'b0);
        repeat (3) @(posedge i_mclk);
        check("irq", o_irq, 1'b1);
        rd(OFS_FLAG, 8'h01);
        rd(OFS_CTRL0, 8'h80);
        repeat (50) @(posedge i_mclk);
        rd(OFS_FLAG, 8'h01);
        wr(OFS_FLAG, 8'h01);
        repeat (3) @(posedge i_mclk);
        check("irq", o_irq, 1'b0);
        wr(OFS_IRQEN, 8'h00);
        wr(OFS_CTRL0, 8'h81);
        wait_run(1'b1);
        wait_run(1'b0);
        repeat (3) @(posedge i_mclk);
        rd(OFS_FLAG, 8'h01);
        check("irq", o_irq, 1'b0);
        wr(OFS_FLAG, 8'h01);
        wr(OFS_CTRL0, 8'h01);
        repeat (20) @(posedge i_mclk);
        check("off", o_conv_run, 1'b0);
        rd(5'h1C, 8'h00);
        wr(OFS_CTRL0, 8'h80);
        i_sleep <= 1'b1;
        i_ext_trig <= 1'b1;
        repeat (30) @(posedge i_mclk);
        i_ext_trig <= 1'b0;
        check("sleep", o_conv_run, 1'b0);
        i_sleep <= 1'b0;
        wait_run(1'b1);
        wait_run(1'b0);
        wr(OFS_FLAG, 8'h01);
        wr(OFS_IRQEN, 8'h03);
        wr(OFS_CTRL0, 8'h90);
        i_sleep <= 1'b1;
        wr(OFS_CTRL0, 8'h91);
        wait_run(1'b1);
        wait_run(1'b0);
        repeat (30) @(posedge i_mclk);
        check("wake", o_wake, 1'b1);
        check("inline", o_resume_inline, 1'b1);
        wr(OFS_IRQEN, 8'h07);
        repeat (30) @(posedge i_mclk);
        check("inline", o_resume_inline, 1'b0);
        // sleep conversion with the interrupt off shuts the core down
        wr(OFS_FLAG, 8'h01);
        wr(OFS_IRQEN, 8'h00);
        wr(OFS_CTRL0, 8'h91);
        wait_run(1'b1);
        wait_run(1'b0);
        repeat (3) @(posedge i_mclk);
        check("core_off", o_core_on, 1'b0);
        rd(OFS_STAT, 8'h11);
        i_sleep <= 1'b0;
        // reset straight after a start write, before run rises, clears every output and every register but the state, which loads ST_IDLE
        wr(OFS_CTRL0, 8'h81);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        check("rst_run", o_conv_run, 1'b0);
        check("rst_on", o_core_on, 1'b0);
        check("rst_irq", {o_irq, o_wake, o_resume_inline}, 3'h0);
        check("rst_sel", {o_mux, o_ref}, 10'h000);
        i_rst <= 1'b0;
        rd(OFS_FLAG, 8'h00);
        rd(OFS_CTRL0, 8'h00);
        give_verdict();
    end
endmodule

`default_nettype wire
